// File: bench/fbe_flash_model.sv
// flash array model that returns the verify result of each block erase
module fbe_flash_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic erase_busy,
    input wire logic [1:0] erase_block,
    output logic verify_fail
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] starts_q [4]; // erase starts seen per block, saturating
    logic busy_q; // busy one cycle back, finds the start edge
    logic idle_pat_q; // toggling level shown while no erase runs
    // counts erase starts per block; an idle line never holds its last value
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
            idle_pat_q <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                starts_q[i] <= 2'h0;
            end
        end else begin
            busy_q <= erase_busy;
            idle_pat_q <= ~idle_pat_q;
            // a new erase run on a block that has not saturated
            if (erase_busy && !busy_q && starts_q[erase_block] != 2'h3) begin
                starts_q[erase_block] <= starts_q[erase_block] + 2'h1;
            end
        end
    end
    // the first erase of a block fails verify, so software must retry
    assign verify_fail = erase_busy ? (starts_q[erase_block] == 2'h1) : idle_pat_q;
endmodule // fbe_flash_model

// File: bench/tb_top.sv
// self-checking bench for the block erase control
`include "fbe_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int EC = 40; // shortened erase length
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1; // clock enable, dropped once during an erase
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic nmi_event = 1'b0;
    logic wdt_event = 1'b0;
    logic irq_req = 1'b0; // never raised in mode zero
    logic verify_fail;
    logic erase_busy;
    logic ew_mode_one;
    logic rewrite_en;
    logic [1:0] erase_block;
    int err_count = 0;
    int num_checks = 0;
    int seed = 54779;
    int n;
    logic [65:0] exp_q [$]; // mask and value of each pending read
    logic [1:0] rblk; // randomly chosen block
    fbe_ctrl #(.ERASE_CYCLES(EC)) i_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .nmi_event(nmi_event), .wdt_event(wdt_event),
        .irq_req(irq_req), .verify_fail(verify_fail), .erase_busy(erase_busy),
        .erase_block(erase_block), .ew_mode_one(ew_mode_one), .rewrite_en(rewrite_en));
    fbe_flash_model i_flash (.clk(clk), .reset_n(reset_n), .erase_busy(erase_busy),
        .erase_block(erase_block), .verify_fail(verify_fail));
    // free running clock, 5 ns period
    always #2.5 clk = ~clk;
    // prints counts and verdict, ends the run
    task summarize();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // compares a port value with its expectation
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // compares masked error and read data with the oldest note
    task cmp_rd(input logic [32:0] got, input logic [65:0] note);
        num_checks++;
        if ((got & note[65:33]) !== note[32:0]) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got & note[65:33], note[32:0]);
        end
    endtask
    // one apb transfer: setup, then access held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // register write
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // register read, noting the masked expectation of {error, data}
    task rd(input logic [7:0] a, input logic [32:0] m, input logic [32:0] e);
        exp_q.push_back({m, e});
        apb(1'b0, a, 32'h0);
    endtask
    // two-cycle erase command to block b with given confirm code and low address
    task erase(input logic [1:0] b, input logic [7:0] code, input logic [10:0] low);
        logic [19:0] fa;
        fa = {7'h00, b, low};
        wr(`FBE_OFF_CMD, {24'h0, `FBE_CMD_ERASE});
        wr(`FBE_OFF_CMD, {4'h0, fa, code});
        #1;
    endtask
    // waits, bounded, until the erase has finished; no other bus traffic meanwhile
    task wait_idle();
        for (int i = 0; i < 4 * EC && erase_busy !== 1'b0; i++) begin
            @(posedge clk);
        end
        #1;
    endtask
    // write of 0 directly followed by 1 on a protected bit
    task unlock(input logic [7:0] a, input int b);
        wr(a, 32'h0); // nmi_event stays low across the pair
        wr(a, 32'h1 << b);
        #1;
    endtask
    // watcher: each completed read is compared with the oldest note
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                cmp_rd({pslverr, prdata}, exp_q.pop_front());
            end
        end
    end
    // watchdog against a hang
    initial begin
        #100us;
        err_count++;
        summarize();
    end
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        chk({erase_busy, rewrite_en, ew_mode_one, erase_block}, 32'h0);
        wr(8'h18, $random(seed));
        rd(8'h18, 33'h1FFFFFFFF, 33'h100000000);
        wr(`FBE_OFF_CTRL0, 32'h2);
        #1;
        chk(rewrite_en, 32'h0);
        wr(`FBE_OFF_CTRL0, 32'h0);
        wr(`FBE_OFF_PROT, 32'h0);
        wr(`FBE_OFF_CTRL0, 32'h2);
        #1;
        chk(rewrite_en, 32'h0);
        unlock(`FBE_OFF_CTRL0, `FBE_B_REWR);
        chk(rewrite_en, 32'h1);
        erase(2'h2, 8'h40, 11'h7FE);
        chk(erase_busy, 32'h0);
        erase(2'h2, `FBE_CMD_CONF, 11'h7FF);
        chk(erase_busy, 32'h0);
        wr(`FBE_OFF_PROT, 32'h2);
        erase(2'h1, `FBE_CMD_CONF, 11'h7FE);
        chk(erase_busy, 32'h0);
        rd(`FBE_OFF_CTRL0, 33'h80, 33'h80);
        wr(`FBE_OFF_PROT, 32'h0);
        wr(`FBE_OFF_CMD, {24'h0, `FBE_CMD_CLRSR});
        rd(`FBE_OFF_CTRL0, 33'h80, 33'h0);
        erase(2'h2, `FBE_CMD_CONF, 11'h7FE);
        chk({erase_busy, erase_block}, 32'h6);
        rd(`FBE_OFF_CTRL0, 33'h81, 33'h0);
        rd(`FBE_OFF_CTRL4, 33'h40, 33'h0);
        rd(`FBE_OFF_STAT, 33'h1A0, 33'h100);
        wait_idle();
        rd(`FBE_OFF_CTRL0, 33'h81, 33'h81);
        rd(`FBE_OFF_CTRL4, 33'h40, 33'h40);
        rd(`FBE_OFF_STAT, 33'h1A0, 33'h1A0);
        wr(`FBE_OFF_CMD, {24'h0, `FBE_CMD_CLRSR});
        erase(2'h2, `FBE_CMD_CONF, 11'h7FE);
        // freeze three edges with the clock enable low; the erase must stretch by three
        @(posedge clk);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        chk(pready, 32'h0); // bus stalls while frozen
        ce <= 1'b1;
        #1;
        chk(erase_busy, 32'h1);
        n = 4;
        while (erase_busy === 1'b1 && n < 4 * EC) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n, EC + 3);
        rd(`FBE_OFF_CTRL0, 33'h81, 33'h01);
        wr(`FBE_OFF_CMD, {24'h0, `FBE_CMD_RDARR});
        rd(`FBE_OFF_STAT, 33'h100, 33'h0);
        rblk = 2'($random(seed));
        erase(rblk, `FBE_CMD_CONF, 11'h7FE);
        chk(erase_block, rblk);
        wr(`FBE_OFF_CTRL4, 32'h3);
        @(posedge clk);
        #1;
        chk(erase_busy, 32'h0);
        rd(`FBE_OFF_CTRL4, 33'h40, 33'h40);
        wr(`FBE_OFF_CTRL4, 32'h1);
        @(posedge clk);
        #1;
        chk(erase_busy, 32'h1);
        wait_idle();
        unlock(`FBE_OFF_CTRL1, `FBE_B_MODE);
        chk(ew_mode_one, 32'h1);
        erase(2'h3, `FBE_CMD_CONF, 11'h7FE); // block 3 holds no running program
        @(posedge clk);
        irq_req <= 1'b1; // raised only with suspend enabled
        repeat (2) @(posedge clk);
        irq_req <= 1'b0;
        #1;
        chk(erase_busy, 32'h0);
        wr(`FBE_OFF_CTRL4, 32'h1);
        @(posedge clk);
        #1;
        chk(erase_busy, 32'h1);
        wait_idle();
        for (int k = 0; k < 2; k++) begin
            unlock(`FBE_OFF_CTRL1, `FBE_B_MODE);
            erase(2'h0, `FBE_CMD_CONF, 11'h7FE);
            @(posedge clk);
            nmi_event <= (k == 0);
            wdt_event <= (k == 1);
            @(posedge clk);
            nmi_event <= 1'b0;
            wdt_event <= 1'b0;
            #1;
            chk({erase_busy, rewrite_en, ew_mode_one}, 32'h0);
            rd(`FBE_OFF_CTRL0, 33'h06, 33'h0);
            unlock(`FBE_OFF_CTRL0, `FBE_B_REWR);
        end
        erase(2'h0, `FBE_CMD_CONF, 11'h7FE); // aborted block erased before any retry
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        #1;
        chk({erase_busy, rewrite_en}, 32'h0);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        summarize();
    end
endmodule // tb_top

// File: hw/fbe_cfg.svh
// offsets, bit positions, command codes and counts of the block erase control
`ifndef FBE_CFG_SVH
`define FBE_CFG_SVH
`define FBE_OFF_CTRL0 8'h00
`define FBE_OFF_CTRL1 8'h04
`define FBE_OFF_CTRL4 8'h08
`define FBE_OFF_CMD 8'h0C
`define FBE_OFF_STAT 8'h10
`define FBE_OFF_PROT 8'h14
`define FBE_B_READY 0
`define FBE_B_REWR 1
`define FBE_B_LOCK 2
`define FBE_B_ERR 7
`define FBE_B_MODE 1
`define FBE_B_PFC 6
`define FBE_B_SUSEN 0
`define FBE_B_SUSRQ 1
`define FBE_B_SUSENT 6
`define FBE_B_SR_RDY 7
`define FBE_B_SR_ERR 5
`define FBE_B_SR_RSR 8
`define FBE_CODE_LSB 0
`define FBE_CODE_W 8
`define FBE_ADDR_LSB 8
`define FBE_CMD_ERASE 8'h20
`define FBE_CMD_CONF 8'hD0
`define FBE_CMD_RDARR 8'hFF
`define FBE_CMD_CLRSR 8'h50
`define FBE_ERASE_CYC 1000
`endif

// File: hw/fbe_ctrl.sv
// block erase sequencer with apb register access
`include "fbe_cfg.svh"
// How it works
// - erase: code 20 then D0 at highest even address of block
// - ready flag 0 during erase, then 1
// - suspend flag low erasing, high done/suspended
// - error flag reports erase result
// - per-block disable blocks erase
// - mode zero: status mode until read-array
// - status ready bit low while erasing
// - nmi or watchdog reinit control zero/one
// - protected bits set by 0 then 1
// - reset, nmi, watchdog abort running erase
// - mode select bit picks mode zero/one
// - suspend request pauses, clearing resumes erase
module fbe_ctrl #(
    parameter int NBLK = 4, // number of erasable blocks
    parameter int BLK_BITS = 11, // byte address bits per block
    parameter int AW = 20, // flash address width
    parameter int ERASE_CYCLES = `FBE_ERASE_CYC // erase length
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic nmi_event,
    input wire logic wdt_event,
    input wire logic irq_req,
    input wire logic verify_fail,
    output logic erase_busy,
    output logic [$clog2(NBLK)-1:0] erase_block,
    output logic ew_mode_one,
    output logic rewrite_en
);
    localparam int BW = $clog2(NBLK);
    localparam int CW = $clog2(ERASE_CYCLES + 1);
    localparam logic [CW-1:0] CNT_LOAD = CW'(ERASE_CYCLES - 1);

    fbe_pkg::fbe_state_e state_q; // sequencer state
    logic [CW-1:0] cnt_q; // erase cycles left
    logic [BW-1:0] blk_q; // block under erase
    logic err_q; // erase error flag
    logic rsr_q; // read status mode
    logic sus_en_q; // suspend enable
    logic sus_rq_q; // suspend request
    logic [NBLK-1:0] prot_q; // per block erase disable
    logic lock_q; // lock release bit
    logic pfc_q; // other protected control bit
    logic [31:0] prdata_q; // read data
    logic pslverr_q; // error answer

    logic abort; // nmi or watchdog this cycle
    logic wr_en; // write takes effect
    logic setup; // apb setup phase
    logic cmd_wr; // flash command cycle
    logic [7:0] code; // command code
    logic [AW-1:0] faddr; // flash address of the cycle
    logic [BW-1:0] fblk; // block addressed
    logic top_even; // highest even address of block
    logic confirm; // valid confirm cycle
    logic start; // erase starts
    logic done; // erase finished
    logic ready; // erase ready flag
    logic sus_ent; // suspend entered flag
    logic sus_go; // enter suspend
    logic busy; // erase in progress
    logic hit; // address is mapped
    logic [31:0] rd_val; // value to read

    // apb decode; the bus stalls while the clock enable is low
    assign pready = ce;
    assign setup = psel && !penable && ce;
    assign wr_en = psel && penable && pwrite && ce;
    assign abort = ce && (nmi_event || wdt_event);
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    // command cycle fields
    assign cmd_wr = wr_en && (paddr == `FBE_OFF_CMD);
    assign code = pwdata[`FBE_CODE_LSB +: `FBE_CODE_W];
    assign faddr = pwdata[`FBE_ADDR_LSB +: AW];
    assign fblk = faddr[BLK_BITS +: BW];
    assign top_even = (&faddr[BLK_BITS-1:1]) && !faddr[0];
    assign confirm = cmd_wr && (code == `FBE_CMD_CONF) && top_even;
    assign start = (state_q == fbe_pkg::FBE_SETUP) && confirm && !prot_q[fblk] && !abort;

    // flags from the state
    assign busy = (state_q == fbe_pkg::FBE_ERASE) || (state_q == fbe_pkg::FBE_SUSP);
    assign ready = !busy;
    assign sus_ent = (state_q != fbe_pkg::FBE_ERASE);
    assign sus_go = sus_en_q && sus_rq_q;
    assign done = (state_q == fbe_pkg::FBE_ERASE) && !sus_go && (cnt_q == '0);
    assign erase_busy = (state_q == fbe_pkg::FBE_ERASE);
    assign erase_block = blk_q;

    // protected control bits
    fbe_unlock_bit u_rewr (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .clr(abort),
        .own_wr(wr_en && (paddr == `FBE_OFF_CTRL0)),
        .any_wr(wr_en),
        .wbit(pwdata[`FBE_B_REWR]),
        .val_q(rewrite_en)
    );
    fbe_unlock_bit u_lock (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .clr(abort),
        .own_wr(wr_en && (paddr == `FBE_OFF_CTRL0)),
        .any_wr(wr_en),
        .wbit(pwdata[`FBE_B_LOCK]),
        .val_q(lock_q)
    );
    // mode select: 0 picks mode zero, 1 picks mode one
    fbe_unlock_bit u_mode (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .clr(abort),
        .own_wr(wr_en && (paddr == `FBE_OFF_CTRL1) && rewrite_en),
        .any_wr(wr_en),
        .wbit(pwdata[`FBE_B_MODE]),
        .val_q(ew_mode_one)
    );
    fbe_unlock_bit u_pfc (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .clr(abort),
        .own_wr(wr_en && (paddr == `FBE_OFF_CTRL1)),
        .any_wr(wr_en),
        .wbit(pwdata[`FBE_B_PFC]),
        .val_q(pfc_q)
    );

    // sequencer; nmi or watchdog halts any erase at once
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= fbe_pkg::FBE_IDLE;
        end else if (abort) begin
            state_q <= fbe_pkg::FBE_IDLE;
        end else if (ce) begin
            unique case (state_q)
                fbe_pkg::FBE_IDLE: begin
                    // erase command only accepted while rewrite mode is on
                    if (cmd_wr && rewrite_en && (code == `FBE_CMD_ERASE)) begin
                        state_q <= fbe_pkg::FBE_SETUP;
                    end
                end
                fbe_pkg::FBE_SETUP: begin
                    if (start) begin
                        state_q <= fbe_pkg::FBE_ERASE;
                    end else if (cmd_wr) begin
                        state_q <= fbe_pkg::FBE_IDLE;
                    end
                end
                fbe_pkg::FBE_ERASE: begin
                    if (sus_go) begin
                        state_q <= fbe_pkg::FBE_SUSP;
                    end else if (done) begin
                        state_q <= fbe_pkg::FBE_IDLE;
                    end
                end
                fbe_pkg::FBE_SUSP: begin
                    if (!sus_rq_q) begin
                        state_q <= fbe_pkg::FBE_ERASE;
                    end
                end
            endcase
        end
    end

    // erase timer and block latch; suspend holds the count
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
            blk_q <= '0;
        end else if (ce) begin
            if (start) begin
                cnt_q <= CNT_LOAD;
                blk_q <= fblk;
            end else if ((state_q == fbe_pkg::FBE_ERASE) && !sus_go && (cnt_q != '0)) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // erase error; a fresh error wins over clear status
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            err_q <= 1'b0;
        end else if (abort) begin
            err_q <= 1'b0;
        end else if (ce) begin
            if (done && verify_fail) begin
                err_q <= 1'b1;
            end else if ((state_q == fbe_pkg::FBE_SETUP) && confirm && prot_q[fblk]) begin
                err_q <= 1'b1;
            end else if (cmd_wr && ready && (code == `FBE_CMD_CLRSR)) begin
                err_q <= 1'b0;
            end
        end
    end

    // read status mode, entered at erase start in mode zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rsr_q <= 1'b0;
        end else if (abort) begin
            rsr_q <= 1'b0;
        end else if (ce) begin
            if (start && !ew_mode_one) begin
                rsr_q <= 1'b1;
            end else if (cmd_wr && ready && (code == `FBE_CMD_RDARR)) begin
                rsr_q <= 1'b0;
            end
        end
    end

    // suspend controls; in mode one an interrupt raises the request
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sus_en_q <= 1'b0;
            sus_rq_q <= 1'b0;
        end else if (ce) begin
            if (wr_en && (paddr == `FBE_OFF_CTRL4)) begin
                sus_en_q <= pwdata[`FBE_B_SUSEN];
                sus_rq_q <= pwdata[`FBE_B_SUSRQ];
            end
            if (ew_mode_one && sus_en_q && irq_req && (state_q == fbe_pkg::FBE_ERASE)) begin
                sus_rq_q <= 1'b1; // set wins over the write
            end
        end
    end

    // erase disable bits per block
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prot_q <= '0;
        end else if (ce && wr_en && (paddr == `FBE_OFF_PROT)) begin
            prot_q <= pwdata[NBLK-1:0];
        end
    end

    // read value mux; unmapped reads give zero
    always_comb begin
        rd_val = '0;
        hit = 1'b1;
        unique case (paddr)
            `FBE_OFF_CTRL0: begin
                rd_val[`FBE_B_READY] = ready;
                rd_val[`FBE_B_REWR] = rewrite_en;
                rd_val[`FBE_B_LOCK] = lock_q;
                rd_val[`FBE_B_ERR] = err_q;
            end
            `FBE_OFF_CTRL1: begin
                rd_val[`FBE_B_MODE] = ew_mode_one;
                rd_val[`FBE_B_PFC] = pfc_q;
            end
            `FBE_OFF_CTRL4: begin
                rd_val[`FBE_B_SUSEN] = sus_en_q;
                rd_val[`FBE_B_SUSRQ] = sus_rq_q;
                rd_val[`FBE_B_SUSENT] = sus_ent;
            end
            `FBE_OFF_CMD: begin
                rd_val = '0;
            end
            `FBE_OFF_STAT: begin
                rd_val[`FBE_B_SR_RDY] = ready;
                rd_val[`FBE_B_SR_ERR] = err_q;
                rd_val[`FBE_B_SR_RSR] = rsr_q;
            end
            `FBE_OFF_PROT: begin
                rd_val[NBLK-1:0] = prot_q;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // apb answer captured in the setup phase
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr_q <= !hit;
        end
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    property p_start;
        start |=> (state_q == fbe_pkg::FBE_ERASE) && !ready;
    endproperty
    a_start: assert property (p_start) else $error("erase did not start");

    property p_done;
        done && !abort && ce |=> ready && sus_ent;
    endproperty
    a_done: assert property (p_done) else $error("ready not set after erase");

    property p_busy;
        (state_q == fbe_pkg::FBE_ERASE) |-> !ready && !sus_ent && (cnt_q <= CNT_LOAD);
    endproperty
    a_busy: assert property (p_busy) else $error("flags wrong while erasing");

    property p_err;
        done && verify_fail && !abort && ce |=> err_q;
    endproperty
    a_err: assert property (p_err) else $error("error flag not set");

    property p_prot;
        (state_q == fbe_pkg::FBE_SETUP) && confirm && prot_q[fblk] && !abort
            |=> (state_q == fbe_pkg::FBE_IDLE) && err_q;
    endproperty
    a_prot: assert property (p_prot) else $error("protected block erased");

    property p_rsr;
        start && !ew_mode_one |=> rsr_q [*2];
    endproperty
    a_rsr: assert property (p_rsr) else $error("status mode not entered");

    property p_abort;
        abort |=> (state_q == fbe_pkg::FBE_IDLE) && !rewrite_en && !ew_mode_one;
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not reinit");

    property p_lock;
        $rose(rewrite_en) |-> $past(wr_en && (paddr == `FBE_OFF_CTRL0) && pwdata[`FBE_B_REWR]);
    endproperty
    a_lock: assert property (p_lock) else $error("protected bit set without write");

    property p_ignore;
        (state_q == fbe_pkg::FBE_SETUP) && cmd_wr && !confirm && !abort |=> !busy;
    endproperty
    a_ignore: assert property (p_ignore) else $error("bad confirm started erase");

    property p_resume;
        (state_q == fbe_pkg::FBE_SUSP) && !sus_rq_q && ce && !abort |=> (state_q == fbe_pkg::FBE_ERASE);
    endproperty
    a_resume: assert property (p_resume) else $error("erase did not resume");

    c_erase: cover property (start ##[1:1000] done);
    c_susp: cover property ((state_q == fbe_pkg::FBE_SUSP) ##1 (state_q == fbe_pkg::FBE_ERASE));
    c_abort: cover property (busy && abort);
endmodule // fbe_ctrl

// File: hw/fbe_pkg.sv
// types shared by the block erase control
package fbe_pkg;
    // sequencer states
    typedef enum logic [1:0] {
        FBE_IDLE = 2'b00,
        FBE_SETUP = 2'b01,
        FBE_ERASE = 2'b10,
        FBE_SUSP = 2'b11
    } fbe_state_e;
endpackage

// File: hw/fbe_unlock_bit.sv
// control bit that only sets when 1 directly follows a write of 0
module fbe_unlock_bit (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic clr,
    input wire logic own_wr,
    input wire logic any_wr,
    input wire logic wbit,
    output logic val_q
);
    logic arm_q; // last write to the bus was a 0 to this bit

    // value and arming; a force clear wins over any write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            val_q <= 1'b0;
            arm_q <= 1'b0;
        end else if (ce) begin
            if (clr) begin
                val_q <= 1'b0;
                arm_q <= 1'b0;
            end else if (own_wr && !wbit) begin
                val_q <= 1'b0;
                arm_q <= 1'b1;
            end else if (own_wr) begin
                if (arm_q) begin
                    val_q <= 1'b1;
                end
                arm_q <= 1'b0;
            end else if (any_wr) begin
                arm_q <= 1'b0; // any other write breaks the pair
            end
        end
    end
endmodule // fbe_unlock_bit
